// >>> shared/lpst_pkg.sv
`default_nettype none
package lpst_pkg;
  localparam int NUM_REGS = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] ADDR_DRV2 = 8'h24;
  localparam logic [7:0] ADDR_FINE = 8'h25;
  localparam logic [7:0] ADDR_A_SHAPE = 8'h30;
  localparam logic [7:0] ADDR_A_CNT = 8'h31;
  localparam logic [7:0] ADDR_DIS = 8'h34;
  localparam logic [7:0] ADDR_B_SHAPE = 8'h35;
  localparam logic [7:0] ADDR_B_CNT = 8'h36;
  localparam logic [7:0] ADDR_PER_HI = 8'h37;
  localparam int IDX_DRV2 = 0;
  localparam int IDX_FINE = 1;
  localparam int IDX_A_SHAPE = 2;
  localparam int IDX_A_CNT = 3;
  localparam int IDX_DIS = 4;
  localparam int IDX_B_SHAPE = 5;
  localparam int IDX_B_CNT = 6;
  localparam int IDX_PER_HI = 7;
  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{ADDR_DRV2, ADDR_FINE,
    ADDR_A_SHAPE, ADDR_A_CNT, ADDR_DIS, ADDR_B_SHAPE, ADDR_B_CNT,
    ADDR_PER_HI};
  localparam logic [15:0] REG_RST [NUM_REGS] = '{16'h3000, 16'h630C,
    16'h0320, 16'h0818, 16'h0000, 16'h0320, 16'h0818, 16'h0000};
  localparam logic [15:0] REG_MASK [NUM_REGS] = '{16'h307F, 16'hFFDF,
    16'h1FFF, 16'hFFFF, 16'h0300, 16'h1FFF, 16'hFFFF, 16'h0303};
  localparam int EDGE_LSB = 4;
  localparam int EDGE_W = 3;
  localparam int COARSE_LSB = 0;
  localparam int COARSE_W = 4;
  localparam int SCALE_BIT = 13;
  localparam int FINE1_LSB = 0;
  localparam int FINE2_LSB = 6;
  localparam int FINE3_LSB = 11;
  localparam int FINE_W = 5;
  localparam int LEN_LSB = 8;
  localparam int LEN_W = 5;
  localparam int DELAY_LSB = 0;
  localparam int NUM_LSB = 8;
  localparam int SPACE_LSB = 0;
  localparam int BYTE_W = 8;
  localparam int SPACE_W = 10;
  localparam int HI_W = 2;
  localparam int DIS_A_BIT = 8;
  localparam int DIS_B_BIT = 9;
  localparam int PER_A_LSB = 0;
  localparam int PER_B_LSB = 8;
  localparam int US_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_ON = 4'h4,
    ST_GAP = 4'h8
  } lpst_state_t;
endpackage
`default_nettype wire

// >>> shared/lpst_slot_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lpst_slot_if;
  logic tick;
  logic start;
  logic enable;
  logic emit_off;
  logic [7:0] delay;
  logic [4:0] len;
  logic [7:0] num;
  logic [9:0] spacing;
  logic busy;
  logic pulse;
  modport ctrl(output tick, start, enable, emit_off, delay, len, num,
    spacing, input busy, pulse);
  modport timer(input tick, start, enable, emit_off, delay, len, num,
    spacing, output busy, pulse);
endinterface
`default_nettype wire

// >>> src/lpst_us_tick.sv
`timescale 1ns/1ps
`default_nettype none
module lpst_us_tick #(
  parameter int DIV = lpst_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_tick;
  localparam logic [15:0] LAST = 16'(DIV - 1);

  always_comb begin
    next_tick = (cnt == LAST);
    next_cnt = next_tick ? 16'h0000 : 16'(cnt + 16'h0001);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end

  tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o |=> !tick_o) else $error("us tick not a single pulse");
endmodule
`default_nettype wire

// >>> src/lpst_slot_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lpst_slot_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  lpst_slot_if.timer slot
);
  lpst_pkg::lpst_state_t st;
  lpst_pkg::lpst_state_t next_st;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [9:0] sp;
  logic [9:0] next_sp;
  logic [7:0] rem;
  logic [7:0] next_rem;
  logic next_pulse;
  logic next_busy;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sp = sp;
    next_rem = rem;
    if (slot.tick && cnt != 8'h00) begin
      next_cnt = 8'(cnt - 8'h01);
    end
    if (slot.tick && sp != 10'h000) begin
      next_sp = 10'(sp - 10'h001);
    end
    unique case (st)
      lpst_pkg::ST_IDLE: begin
        if (slot.start && slot.num != 8'h00) begin
          next_st = lpst_pkg::ST_WAIT;
          next_cnt = slot.delay;
          next_rem = slot.num;
        end
      end
      lpst_pkg::ST_WAIT: begin
        if (cnt == 8'h00) begin
          next_st = lpst_pkg::ST_ON;
          next_cnt = {3'h0, slot.len};
          next_sp = slot.spacing;
        end
      end
      lpst_pkg::ST_ON: begin
        if (cnt == 8'h00) begin
          next_st = lpst_pkg::ST_GAP;
        end
      end
      lpst_pkg::ST_GAP: begin
        if (sp == 10'h000) begin
          if (rem == 8'h01) begin
            next_st = lpst_pkg::ST_IDLE;
          end else begin
            next_rem = 8'(rem - 8'h01);
            next_st = lpst_pkg::ST_ON;
            next_cnt = {3'h0, slot.len};
            next_sp = slot.spacing;
          end
        end
      end
    endcase
    // Only the slot enable stops a slot; emit_off only masks the pulse below.
    if (!slot.enable) begin
      next_st = lpst_pkg::ST_IDLE;
    end
    next_pulse = (next_st == lpst_pkg::ST_ON) && !slot.emit_off;
    next_busy = (next_st != lpst_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= lpst_pkg::ST_IDLE;
      cnt <= 8'h00;
      sp <= 10'h000;
      rem <= 8'h00;
      slot.pulse <= 1'b0;
      slot.busy <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      sp <= next_sp;
      rem <= next_rem;
      slot.pulse <= next_pulse;
      slot.busy <= next_busy;
    end
  end

  // Helper state for checking: pulses begun and count asked for.
  logic [8:0] begun;
  logic [7:0] asked;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      begun <= 9'h000;
      asked <= 8'h00;
    end else if (st == lpst_pkg::ST_IDLE) begin
      begun <= 9'h000;
      asked <= slot.num;
    end else if (next_st == lpst_pkg::ST_ON && st != lpst_pkg::ST_ON) begin
      begun <= 9'(begun + 9'h001);
    end
  end

  pulse_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(slot.busy) && slot.enable |-> begun == {1'b0, asked})
    else $error("wrong number of pulses in slot");
  no_early_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st == lpst_pkg::ST_WAIT && cnt != 8'h00 |=> !slot.pulse)
    else $error("pulse before offset elapsed");
  gap_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st == lpst_pkg::ST_GAP && next_st == lpst_pkg::ST_ON
    |-> sp == 10'h000)
    else $error("pulse restarted before period elapsed");
endmodule
`default_nettype wire

// >>> src/lpst_top.sv
`timescale 1ns/1ps
`default_nettype none
module lpst_top #(
  parameter int TICK_DIV = lpst_pkg::TICK_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic SLOT_A_EN_I,
  input wire logic SLOT_B_EN_I,
  input wire logic SLOT_A_START_I,
  input wire logic SLOT_B_START_I,
  output logic LED_A_PULSE_O,
  output logic LED_B_PULSE_O,
  output logic SLOT_A_BUSY_O,
  output logic SLOT_B_BUSY_O,
  output logic [2:0] DRV2_EDGE_RATE_O,
  output logic [3:0] DRV2_COARSE_CURRENT_O,
  output logic DRV2_SCALE_FULL_O,
  output logic [4:0] DRV1_FINE_MULT_O,
  output logic [4:0] DRV2_FINE_MULT_O,
  output logic [4:0] DRV3_FINE_MULT_O
);
  logic [15:0] regs [lpst_pkg::NUM_REGS];
  logic [15:0] next_regs [lpst_pkg::NUM_REGS];
  logic [15:0] next_rdata;
  logic next_rvalid;
  logic tick;

  // Returns the register index for an address; hit flags a mapped one.
  function automatic logic [3:0] reg_lookup(input logic [7:0] addr);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < lpst_pkg::NUM_REGS; i++) begin
      if (addr == lpst_pkg::REG_ADDR[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  logic [3:0] wr_hit;
  logic [3:0] rd_hit;
  assign wr_hit = reg_lookup(REG_ADDR_I);
  assign rd_hit = wr_hit;

  // Masking at write time keeps reserved bits at zero on read back,
  // whatever software sends, so timing fields never see stray bits.
  always_comb begin
    for (int i = 0; i < lpst_pkg::NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    if (REG_WR_I && wr_hit[3]) begin
      next_regs[wr_hit[2:0]] = REG_WDATA_I & lpst_pkg::REG_MASK[wr_hit[2:0]];
    end
    next_rvalid = REG_RD_I;
    next_rdata = 16'h0000;
    if (REG_RD_I && rd_hit[3]) begin
      next_rdata = regs[rd_hit[2:0]];
    end
  end

  // Each register resets to its own value; the loop keeps them in step.
  generate
    for (genvar g = 0; g < lpst_pkg::NUM_REGS; g++) begin : g_reg
      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          regs[g] <= lpst_pkg::REG_RST[g];
        end else begin
          regs[g] <= next_regs[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 16'h0000;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RDATA_O <= next_rdata;
      REG_RVALID_O <= next_rvalid;
    end
  end

  // Driver settings go out straight from the register flops; the analog
  // side forms the peak current from coarse, fine and scale.
  assign DRV2_EDGE_RATE_O = regs[lpst_pkg::IDX_DRV2]
    [lpst_pkg::EDGE_LSB +: lpst_pkg::EDGE_W];
  assign DRV2_COARSE_CURRENT_O = regs[lpst_pkg::IDX_DRV2]
    [lpst_pkg::COARSE_LSB +: lpst_pkg::COARSE_W];
  assign DRV2_SCALE_FULL_O =
    regs[lpst_pkg::IDX_DRV2][lpst_pkg::SCALE_BIT];
  assign DRV1_FINE_MULT_O = regs[lpst_pkg::IDX_FINE]
    [lpst_pkg::FINE1_LSB +: lpst_pkg::FINE_W];
  assign DRV2_FINE_MULT_O = regs[lpst_pkg::IDX_FINE]
    [lpst_pkg::FINE2_LSB +: lpst_pkg::FINE_W];
  assign DRV3_FINE_MULT_O = regs[lpst_pkg::IDX_FINE]
    [lpst_pkg::FINE3_LSB +: lpst_pkg::FINE_W];

  lpst_us_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_o(tick)
  );

  lpst_slot_if a_if();
  lpst_slot_if b_if();

  assign a_if.tick = tick;
  assign a_if.start = SLOT_A_START_I;
  assign a_if.enable = SLOT_A_EN_I;
  assign a_if.emit_off =
    regs[lpst_pkg::IDX_DIS][lpst_pkg::DIS_A_BIT];
  assign a_if.delay = regs[lpst_pkg::IDX_A_SHAPE]
    [lpst_pkg::DELAY_LSB +: lpst_pkg::BYTE_W];
  assign a_if.len = regs[lpst_pkg::IDX_A_SHAPE]
    [lpst_pkg::LEN_LSB +: lpst_pkg::LEN_W];
  assign a_if.num = regs[lpst_pkg::IDX_A_CNT]
    [lpst_pkg::NUM_LSB +: lpst_pkg::BYTE_W];
  assign a_if.spacing = {
    regs[lpst_pkg::IDX_PER_HI][lpst_pkg::PER_A_LSB +: lpst_pkg::HI_W],
    regs[lpst_pkg::IDX_A_CNT][lpst_pkg::SPACE_LSB +: lpst_pkg::BYTE_W]
  };

  assign b_if.tick = tick;
  assign b_if.start = SLOT_B_START_I;
  assign b_if.enable = SLOT_B_EN_I;
  assign b_if.emit_off =
    regs[lpst_pkg::IDX_DIS][lpst_pkg::DIS_B_BIT];
  assign b_if.delay = regs[lpst_pkg::IDX_B_SHAPE]
    [lpst_pkg::DELAY_LSB +: lpst_pkg::BYTE_W];
  assign b_if.len = regs[lpst_pkg::IDX_B_SHAPE]
    [lpst_pkg::LEN_LSB +: lpst_pkg::LEN_W];
  assign b_if.num = regs[lpst_pkg::IDX_B_CNT]
    [lpst_pkg::NUM_LSB +: lpst_pkg::BYTE_W];
  assign b_if.spacing = {
    regs[lpst_pkg::IDX_PER_HI][lpst_pkg::PER_B_LSB +: lpst_pkg::HI_W],
    regs[lpst_pkg::IDX_B_CNT][lpst_pkg::SPACE_LSB +: lpst_pkg::BYTE_W]
  };

  // A width at or above the period still works: the gap phase is then
  // one clock, so pulses stay one cycle apart rather than the slot hanging.
  lpst_slot_timer u_slot_a (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .slot(a_if.timer)
  );

  lpst_slot_timer u_slot_b (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .slot(b_if.timer)
  );

  assign LED_A_PULSE_O = a_if.pulse;
  assign LED_B_PULSE_O = b_if.pulse;
  assign SLOT_A_BUSY_O = a_if.busy;
  assign SLOT_B_BUSY_O = b_if.busy;

  sequence s_write(logic [7:0] a);
    REG_WR_I && REG_ADDR_I == a;
  endsequence

  sequence s_read(logic [7:0] a);
    REG_RD_I && REG_ADDR_I == a && !REG_WR_I;
  endsequence

  edge_rate_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_write(lpst_pkg::ADDR_DRV2) |=>
    DRV2_EDGE_RATE_O == $past(REG_WDATA_I[6:4]))
    else $error("edge rate not taken from write");
  coarse_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_write(lpst_pkg::ADDR_DRV2) |=>
    DRV2_COARSE_CURRENT_O == $past(REG_WDATA_I[3:0]))
    else $error("coarse current not taken from write");
  scale_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_write(lpst_pkg::ADDR_DRV2) |=>
    DRV2_SCALE_FULL_O == $past(REG_WDATA_I[13]))
    else $error("scale bit not taken from write");
  fine_fields_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_write(lpst_pkg::ADDR_FINE) |=>
    DRV2_FINE_MULT_O == $past(REG_WDATA_I[10:6]) &&
    DRV3_FINE_MULT_O == $past(REG_WDATA_I[15:11]))
    else $error("fine fields misplaced");
  fine_reserved_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_read(lpst_pkg::ADDR_FINE) |=> REG_RVALID_O && !REG_RDATA_O[5] &&
    REG_RDATA_O[4:0] == DRV1_FINE_MULT_O)
    else $error("fine register read back wrong");
  shape_b_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_write(lpst_pkg::ADDR_B_SHAPE) |=>
    b_if.len == $past(REG_WDATA_I[12:8]) &&
    b_if.delay == $past(REG_WDATA_I[7:0]))
    else $error("slot B shape not taken from write");
  period_hi_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_write(lpst_pkg::ADDR_PER_HI) |=>
    a_if.spacing[9:8] == $past(REG_WDATA_I[1:0]) &&
    b_if.spacing[9:8] == $past(REG_WDATA_I[9:8]))
    else $error("period upper bits misplaced");
  emit_off_b_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    b_if.emit_off |=> !LED_B_PULSE_O)
    else $error("slot B pulse while disabled");
  emit_off_a_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    a_if.emit_off |=> !LED_A_PULSE_O)
    else $error("slot A pulse while disabled");
  slot_runs_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    SLOT_A_START_I && SLOT_A_EN_I && !SLOT_A_BUSY_O && a_if.num != 8'h00
    |=> SLOT_A_BUSY_O)
    else $error("slot A did not start");
  count_b_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(SLOT_B_BUSY_O) |-> $past(b_if.num) != 8'h00)
    else $error("slot B started with zero count");
endmodule
`default_nettype wire

// >>> verification/lpst_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en_a = 1'b0;
  logic en_b = 1'b0;
  logic st_a = 1'b0;
  logic st_b = 1'b0;
  logic [15:0] rdata;
  logic rvalid, led_a, led_b, busy_a, busy_b, scale;
  logic [2:0] edge_rate;
  logic [3:0] coarse;
  logic [4:0] fine1, fine2, fine3;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  lpst_top #(.TICK_DIV(DIV)) i_lpst_top (
    .CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .SLOT_A_EN_I(en_a), .SLOT_B_EN_I(en_b),
    .SLOT_A_START_I(st_a), .SLOT_B_START_I(st_b), .LED_A_PULSE_O(led_a),
    .LED_B_PULSE_O(led_b), .SLOT_A_BUSY_O(busy_a), .SLOT_B_BUSY_O(busy_b),
    .DRV2_EDGE_RATE_O(edge_rate), .DRV2_COARSE_CURRENT_O(coarse),
    .DRV2_SCALE_FULL_O(scale), .DRV1_FINE_MULT_O(fine1),
    .DRV2_FINE_MULT_O(fine2), .DRV3_FINE_MULT_O(fine3)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The longest scenario needs about 2100 cycles; the ceiling leaves margin.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count = err_count + 1;
      print_verdict();
    end
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic check_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Timing is counted in free-running ticks of DIV = 4 clocks, so a tolerance
  // of about one tick is the tightest bound that a correct design keeps.
  task automatic check_near(input string what, input int exp, input int got,
                            input int tol);
    cmp_count++;
    if (got < exp - tol || got > exp + tol) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // The extra cycle keeps two back-to-back writes from reassigning the
  // strobe within one time step.
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step();
    wr = 1'b0;
    step();
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    addr = a;
    rd = 1'b1;
    step();
    rd = 1'b0;
    for (int i = 0; i < 3 && rvalid !== 1'b1; i++) step();
    d = (rvalid === 1'b1) ? rdata : 16'hDEAD;
    step();
  endtask

  task automatic t_reset();
    logic [15:0] d;
    for (int i = 0; i < lpst_pkg::NUM_REGS; i++) begin
      reg_read(lpst_pkg::REG_ADDR[i], d);
      check_val("reset value", lpst_pkg::REG_RST[i], d);
    end
    check_val("drv1 fine", 16'h000C, {11'h000, fine1});
    check_val("drv2 fine", 16'h000C, {11'h000, fine2});
    check_val("drv3 fine", 16'h000C, {11'h000, fine3});
    check_val("edge rate", 16'h0000, {13'h0000, edge_rate});
    check_val("coarse", 16'h0000, {12'h000, coarse});
    check_val("scale", 16'h0001, {15'h0000, scale});
  endtask

  task automatic t_regs();
    logic [15:0] d;
    for (int i = 0; i < lpst_pkg::NUM_REGS; i++) begin
      reg_write(lpst_pkg::REG_ADDR[i], 16'hFFFF);
      reg_read(lpst_pkg::REG_ADDR[i], d);
      check_val("masked readback", lpst_pkg::REG_MASK[i], d);
    end
    check_val("edge rate max", 16'h0007, {13'h0000, edge_rate});
    check_val("coarse max", 16'h000F, {12'h000, coarse});
    check_val("drv1 fine max", 16'h001F, {11'h000, fine1});
    check_val("drv2 fine max", 16'h001F, {11'h000, fine2});
    check_val("drv3 fine max", 16'h001F, {11'h000, fine3});
    reg_write(lpst_pkg::ADDR_DRV2, 16'h1025);
    check_val("edge rate", 16'h0002, {13'h0000, edge_rate});
    check_val("coarse", 16'h0005, {12'h000, coarse});
    check_val("scale low", 16'h0000, {15'h0000, scale});
    reg_write(8'h40, 16'hFFFF);
    reg_read(8'h40, d);
    check_val("unmapped read", 16'h0000, d);
    for (int i = 0; i < lpst_pkg::NUM_REGS; i++)
      reg_write(lpst_pkg::REG_ADDR[i], lpst_pkg::REG_RST[i]);
  endtask

  // Runs one slot to completion; a second start is pulsed mid-run and
  // must be ignored.
  task automatic run_slot(input bit b, input int n, input int per,
                          input int wid, input int off, input bit dark);
    int rises, first, last, spc, hi, bl;
    logic prev, led, busy;
    rises = 0;
    first = -1;
    last = 0;
    spc = 0;
    hi = 0;
    bl = 0;
    prev = 1'b0;
    st_a = !b;
    st_b = b;
    step();
    for (int t = 1; t < 40000; t++) begin
      st_a = (t == 6) && !b;
      st_b = (t == 6) && b;
      led = b ? led_b : led_a;
      busy = b ? busy_b : busy_a;
      if (busy !== 1'b1) break;
      bl++;
      if (led === 1'b1) hi++;
      if (led === 1'b1 && prev !== 1'b1) begin
        rises++;
        if (first < 0) first = t;
        else spc = t - last;
        last = t;
      end
      prev = led;
      step();
    end
    st_a = 1'b0;
    st_b = 1'b0;
    check_near("pulse count", dark ? 0 : n, rises, 0);
    check_near("busy length", (off + n * per) * DIV, bl, 2 * DIV);
    if (!dark) begin
      check_near("offset", off * DIV, first, DIV + 2);
      check_near("total width", n * wid * DIV, hi, n * (DIV + 1));
      if (n > 1) check_near("spacing", per * DIV, spc, DIV);
    end
    step();
  endtask

  task automatic t_slots();
    reg_write(lpst_pkg::ADDR_A_SHAPE, 16'h0201);
    reg_write(lpst_pkg::ADDR_A_CNT, 16'h0305);
    run_slot(1'b0, 3, 5, 2, 1, 1'b0);
    reg_write(lpst_pkg::ADDR_DIS, 16'h0100);
    run_slot(1'b0, 3, 5, 2, 1, 1'b1);
    reg_write(lpst_pkg::ADDR_DIS, 16'h0200);
    run_slot(1'b1, 8, 24, 3, 32, 1'b1);
    reg_write(lpst_pkg::ADDR_DIS, 16'h0000);
    run_slot(1'b1, 8, 24, 3, 32, 1'b0);
  endtask

  task automatic t_period_hi();
    reg_write(lpst_pkg::ADDR_PER_HI, 16'h0102);
    reg_write(lpst_pkg::ADDR_B_SHAPE, 16'h0100);
    reg_write(lpst_pkg::ADDR_B_CNT, 16'h0203);
    run_slot(1'b1, 2, 259, 1, 0, 1'b0);
    reg_write(lpst_pkg::ADDR_A_CNT, 16'h0105);
    run_slot(1'b0, 1, 517, 2, 1, 1'b0);
    reg_write(lpst_pkg::ADDR_PER_HI, 16'h0000);
  endtask

  task automatic t_stop();
    reg_write(lpst_pkg::ADDR_A_CNT, 16'h0005);
    st_a = 1'b1;
    step();
    st_a = 1'b0;
    step();
    check_val("busy at count 0", 16'h0000, {15'h0000, busy_a});
    reg_write(lpst_pkg::ADDR_A_CNT, 16'h0818);
    st_a = 1'b1;
    step();
    st_a = 1'b0;
    repeat (20) step();
    check_val("busy running", 16'h0001, {15'h0000, busy_a});
    en_a = 1'b0;
    step();
    step();
    check_val("busy after disable", 16'h0000, {15'h0000, busy_a});
    en_a = 1'b1;
    step();
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    en_a = 1'b1;
    en_b = 1'b1;
    step();
    t_reset();
    t_regs();
    t_slots();
    t_period_hi();
    t_stop();
    print_verdict();
  end
endmodule
`default_nettype wire
